// ==== rtl/adcc_apb_slave.sv ====
// APB slave front end of the converter control block.
// Assumes the owner decodes wr and supplies rdata for the paddr shown.
`timescale 1ns/1ps
`include "adcc_regs.svh"
module adcc_apb_slave
  import adcc_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Register side
  input  wire logic [7:0]  rdata,
  output adcc_wr_t         wr
);
  logic        pready_q,  pready_d;
  logic        pslverr_q, pslverr_d;
  logic [31:0] prdata_q,  prdata_d;
  logic        mapped;

  assign mapped = (paddr == `ADCC_SC1_OFFS) || (paddr == `ADCC_SC2_OFFS);

  // One wait state, so read data and pready both leave flip-flops
  always_comb begin
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    prdata_d  = prdata_q;
    if (psel && penable && !pready_q) begin
      pready_d  = 1'b1;
      pslverr_d = !mapped;
      prdata_d  = (!pwrite && mapped) ? {24'h000000, rdata} : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  // Write lands on the edge where the master sees pready
  assign wr.en   = psel && penable && pready_q && pwrite && mapped;
  assign wr.addr = paddr;
  assign wr.data = pwdata[7:0];
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
endmodule

// ==== rtl/adcc_ctrl.sv ====
// Control and status of a successive approximation converter.
// Assumes an analog converter answering start with a done strobe,
// and a comparator reporting result below the compare value.
//
// Operation
// R1 - Compare off: every finish sets done flag
// R2 - Compare on: finish sets flag only if true
// R3 - Status one write or result read clears
// R4 - Interrupt when flag set and enable high
// R5 - Single mode: one conversion per trigger
// R6 - Continuous mode: back-to-back after first trigger
// R7 - Five-bit channel select in status one
// R8 - Codes map external, reserved, high, low reference
// R9 - All-ones code turns converter off, isolated
// R10 - All-ones stop allows no further conversion
// R11 - Single mode idles in low power after finish
// R12 - Active flag spans conversion, clears on abort
// R13 - Trigger select: software write or hardware
// R14 - Compare enable bit in status two
// R15 - Compare sense: below, or greater-equal
// R16 - Status one write aborts, restarts unless off (in hardware trigger mode the code only re-arms and waits for the next edge)
// R17 - Result loads unless compare fails
// R18 - Hardware trigger synchronised, rising edge only
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "adcc_regs.svh"
module adcc_ctrl
  import adcc_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Hardware trigger
  input  wire logic        hw_trigger_in,
  // Converter and result registers
  input  adcc_rsp_t        conv_rsp,
  input  wire logic        result_low_rd,
  output adcc_req_t        conv_req,
  output logic             result_load,
  // Interrupt
  output logic             done_irq
);
  adcc_wr_t    wr;
  logic [7:0]  rdata;
  logic        hw_evt;

  adcc_state_t state_q, state_d;
  logic        conversion_done_flag_q, conversion_done_flag_d;
  logic        done_irq_enable_q, done_irq_enable_d;
  logic        continuous_enable_q, continuous_enable_d;
  logic [4:0]  channel_select_q, channel_select_d;
  logic        trigger_select_q, trigger_select_d;
  logic        compare_enable_q, compare_enable_d;
  logic        compare_greater_equal_q, compare_greater_equal_d;
  logic        armed_q, armed_d;
  adcc_req_t   req_q, req_d;
  logic        load_q, load_d;
  logic        irq_q, irq_d;

  logic        sc1_wr;
  logic        sc2_wr;
  logic        cmp_true;
  logic        finish;
  logic        hit;
  logic        go;
  logic        wr_off;

  // Channel code to source
  function automatic adcc_src_t chan_src(input logic [4:0] ch);
    adcc_src_t s;
    s = ADCC_SRC_EXT;
    if (ch == `ADCC_CH_OFF) begin
      s = ADCC_SRC_OFF;
    end else if (ch == `ADCC_CH_VREFL) begin
      s = ADCC_SRC_VREFL;
    end else if (ch == `ADCC_CH_VREFH) begin
      s = ADCC_SRC_VREFH;
    end else if (ch == `ADCC_CH_RSVD) begin
      s = ADCC_SRC_RSVD;
    end
    return s;
  endfunction

  adcc_apb_slave u_apb (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .rdata   (rdata),
    .wr      (wr)
  );

  adcc_trig_sync u_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .trig_in   (hw_trigger_in),
    .trig_rise (hw_evt)
  );

  assign sc1_wr = wr.en && (wr.addr == `ADCC_SC1_OFFS);
  assign sc2_wr = wr.en && (wr.addr == `ADCC_SC2_OFFS);
  assign wr_off = (wr.data[`ADCC_CH_MSB:0] == `ADCC_CH_OFF);

  // A write in the same cycle as done aborts, so that finish is dropped
  assign finish   = (state_q == ADCC_CONV) && conv_rsp.done && !sc1_wr;
  assign cmp_true = compare_greater_equal_q ? !conv_rsp.below // [R15]
                                            : conv_rsp.below;
  assign hit      = finish && (!compare_enable_q || cmp_true); // [R1] [R2]

  always_comb begin
    rdata = 8'h00;
    if (paddr == `ADCC_SC1_OFFS) begin
      rdata = {conversion_done_flag_q, done_irq_enable_q,
               continuous_enable_q, channel_select_q};
    end else if (paddr == `ADCC_SC2_OFFS) begin
      rdata = {state_q == ADCC_CONV, trigger_select_q,
               compare_enable_q, compare_greater_equal_q, 4'h0};
    end
  end

  always_comb begin
    state_d                 = state_q;
    done_irq_enable_d       = done_irq_enable_q;
    continuous_enable_d     = continuous_enable_q;
    channel_select_d        = channel_select_q;
    trigger_select_d        = trigger_select_q;
    compare_enable_d        = compare_enable_q;
    compare_greater_equal_d = compare_greater_equal_q;
    armed_d                 = armed_q;
    go                      = 1'b0;
    req_d                   = req_q;
    req_d.start             = 1'b0;
    req_d.abort             = 1'b0;
    load_d                  = hit; // [R17]
    if (sc2_wr) begin
      trigger_select_d        = wr.data[`ADCC_TRG_BIT]; // [R13]
      compare_enable_d        = wr.data[`ADCC_CMPEN_BIT]; // [R14]
      compare_greater_equal_d = wr.data[`ADCC_CMPGE_BIT]; // [R15]
    end
    if (sc1_wr) begin
      done_irq_enable_d   = wr.data[`ADCC_IEN_BIT];
      continuous_enable_d = wr.data[`ADCC_CONT_BIT];
      channel_select_d    = wr.data[`ADCC_CH_MSB:0]; // [R7]
      req_d.abort         = (state_q == ADCC_CONV); // [R16]
      state_d             = ADCC_IDLE; // [R12]
      // Hardware mode waits for the next trigger edge instead
      armed_d             = !wr_off; // [R10]
      go                  = !wr_off && !trigger_select_q; // [R13] [R16]
    end else begin
      case (state_q)
        ADCC_IDLE: begin
          go = armed_q && trigger_select_q && hw_evt; // [R5] [R18]
        end
        ADCC_CONV: begin
          if (conv_rsp.done) begin
            if (continuous_enable_q) begin
              go = 1'b1; // [R6]
            end else begin
              state_d = ADCC_IDLE; // [R5] [R11]
            end
          end
        end
        default: begin
          state_d = ADCC_IDLE;
        end
      endcase
    end
    if (go) begin
      state_d     = ADCC_CONV; // [R12]
      req_d.start = 1'b1;
    end
    req_d.chan  = channel_select_d;
    req_d.src   = chan_src(channel_select_d); // [R8] [R9]
    // Converter sleeps whenever nothing is converting
    req_d.pwrdn = (state_d == ADCC_IDLE); // [R9] [R11]
  end

  // Set wins over a clear in the same cycle
  always_comb begin
    conversion_done_flag_d = hit || (conversion_done_flag_q && // [R1] [R2]
                             !(sc1_wr || result_low_rd)); // [R3]
    irq_d = conversion_done_flag_d && done_irq_enable_d; // [R4]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q                 <= ADCC_IDLE;
      conversion_done_flag_q  <= 1'(`ADCC_SC1_RST >> `ADCC_DONE_BIT);
      done_irq_enable_q       <= 1'b0;
      continuous_enable_q     <= 1'b0;
      channel_select_q        <= `ADCC_CH_OFF;
      trigger_select_q        <= 1'b0;
      compare_enable_q        <= 1'b0;
      compare_greater_equal_q <= 1'b0;
      armed_q                 <= 1'b0;
      req_q                   <= '{start: 1'b0, abort: 1'b0, pwrdn: 1'b1,
                                   chan: `ADCC_CH_OFF, src: ADCC_SRC_OFF};
      load_q                  <= 1'b0;
      irq_q                   <= 1'b0;
    end else begin
      state_q                 <= state_d;
      conversion_done_flag_q  <= conversion_done_flag_d;
      done_irq_enable_q       <= done_irq_enable_d;
      continuous_enable_q     <= continuous_enable_d;
      channel_select_q        <= channel_select_d;
      trigger_select_q        <= trigger_select_d;
      compare_enable_q        <= compare_enable_d;
      compare_greater_equal_q <= compare_greater_equal_d;
      armed_q                 <= armed_d;
      req_q                   <= req_d;
      load_q                  <= load_d;
      irq_q                   <= irq_d;
    end
  end

  assign conv_req    = req_q;
  assign result_load = load_q;
  assign done_irq    = irq_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_done_plain;
    finish && !compare_enable_q |=> conversion_done_flag_q;
  endproperty
  a_done_plain: assert property (p_done_plain) // [R1]
    else $error("finish without compare did not set done flag");

  property p_done_cause;
    $rose(conversion_done_flag_q) |-> $past(hit);
  endproperty
  a_done_cause: assert property (p_done_cause) // [R2]
    else $error("done flag rose without a passing finish");

  property p_done_clear;
    conversion_done_flag_q && (sc1_wr || result_low_rd) && !hit
      |=> !conversion_done_flag_q;
  endproperty
  a_done_clear: assert property (p_done_clear) // [R3]
    else $error("done flag survived its clear");

  property p_irq;
    (done_irq_enable_q && conversion_done_flag_q |-> done_irq) and
    (!done_irq_enable_q |-> !done_irq);
  endproperty
  a_irq: assert property (p_irq) // [R4]
    else $error("interrupt does not follow flag and enable");

  property p_single;
    finish && !continuous_enable_q
      |=> state_q == ADCC_IDLE && !conv_req.start && conv_req.pwrdn;
  endproperty
  a_single: assert property (p_single) // [R5]
    else $error("single mode did not stop in low power");

  property p_cont;
    finish && continuous_enable_q |=> conv_req.start && state_q == ADCC_CONV;
  endproperty
  a_cont: assert property (p_cont) // [R6]
    else $error("continuous mode did not restart");

  property p_off_stop;
    sc1_wr && wr_off |=> !conv_req.start && conv_req.src == ADCC_SRC_OFF
      ##1 (!conv_req.start || $past(sc1_wr));
  endproperty
  a_off_stop: assert property (p_off_stop) // [R10]
    else $error("conversion started after off code");

  property p_active;
    conv_req.start |-> state_q == ADCC_CONV && !conv_req.pwrdn;
  endproperty
  a_active: assert property (p_active) // [R12]
    else $error("start without active state");

  property p_ext_src;
    conv_req.chan <= `ADCC_CH_EXTMAX |-> conv_req.src == ADCC_SRC_EXT;
  endproperty
  a_ext_src: assert property (p_ext_src) // [R8]
    else $error("external channel code decoded to another source");

  property p_off_src;
    conv_req.chan == `ADCC_CH_OFF |-> conv_req.src == ADCC_SRC_OFF;
  endproperty
  a_off_src: assert property (p_off_src) // [R9]
    else $error("off code did not isolate the input");

  property p_sleep;
    conv_req.pwrdn == (state_q == ADCC_IDLE);
  endproperty
  a_sleep: assert property (p_sleep) // [R11]
    else $error("converter power does not follow the idle state");

  // An armed edge in idle must start, or hardware mode silently stalls
  property p_hw_start;
    state_q == ADCC_IDLE && !sc1_wr && trigger_select_q && armed_q && hw_evt
      |=> conv_req.start;
  endproperty
  a_hw_start: assert property (p_hw_start) // [R13] [R18]
    else $error("armed trigger edge did not start a conversion");

  property p_sw_start;
    sc1_wr && !wr_off && !trigger_select_q |=> conv_req.start;
  endproperty
  a_sw_start: assert property (p_sw_start) // [R13]
    else $error("software write did not start a conversion");

  property p_abort;
    sc1_wr && state_q == ADCC_CONV |=> conv_req.abort;
  endproperty
  a_abort: assert property (p_abort) // [R16]
    else $error("write during conversion did not abort");

  property p_load;
    result_load |-> $past(finish) &&
      (!$past(compare_enable_q) || $past(cmp_true));
  endproperty
  a_load: assert property (p_load) // [R17]
    else $error("result loaded without passing finish");

  property p_cov_cmp;
    finish && compare_enable_q && cmp_true;
  endproperty
  c_cmp: cover property (p_cov_cmp);

  property p_cov_hw;
    trigger_select_q && hw_evt && armed_q ##1 conv_req.start;
  endproperty
  c_hw: cover property (p_cov_hw);

  property p_cov_abort;
    conv_req.abort ##1 conv_req.start;
  endproperty
  c_abort: cover property (p_cov_abort);

  property p_cov_cont;
    finish && continuous_enable_q && trigger_select_q;
  endproperty
  c_cont: cover property (p_cov_cont);
endmodule

// ==== rtl/adcc_pkg.sv ====
// Types shared by the converter control block and its helpers.
// Assumes adcc_regs.svh on the include path.
`include "adcc_regs.svh"
package adcc_pkg;
  typedef enum logic [1:0] {
    ADCC_IDLE,
    ADCC_CONV
  } adcc_state_t;

  typedef enum logic [2:0] {
    ADCC_SRC_EXT,
    ADCC_SRC_RSVD,
    ADCC_SRC_VREFH,
    ADCC_SRC_VREFL,
    ADCC_SRC_OFF
  } adcc_src_t;

  // Request to the analog converter
  typedef struct packed {
    logic       start;
    logic       abort;
    logic       pwrdn;
    logic [4:0] chan;
    adcc_src_t  src;
  } adcc_req_t;

  // Answer of the analog converter and its comparator
  typedef struct packed {
    logic done;
    logic below;
  } adcc_rsp_t;

  // Register write taken from the bus
  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } adcc_wr_t;
endpackage

// ==== rtl/adcc_regs.svh ====
// Register map, field positions, reset values and codes of the
// converter control block. Included by the package, adcc_apb_slave and adcc_ctrl.
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH
`define ADCC_SC1_OFFS  8'h00
`define ADCC_SC2_OFFS  8'h04
`define ADCC_SC1_RST   8'h1f
`define ADCC_SC2_RST   8'h00
`define ADCC_DONE_BIT  7
`define ADCC_IEN_BIT   6
`define ADCC_CONT_BIT  5
`define ADCC_CH_MSB    4
`define ADCC_ACT_BIT   7
`define ADCC_TRG_BIT   6
`define ADCC_CMPEN_BIT 5
`define ADCC_CMPGE_BIT 4
`define ADCC_CH_EXTMAX 5'h1b
`define ADCC_CH_RSVD   5'h1c
`define ADCC_CH_VREFH  5'h1d
`define ADCC_CH_VREFL  5'h1e
`define ADCC_CH_OFF    5'h1f
`endif

// ==== rtl/adcc_trig_sync.sv ====
// Hardware trigger synchroniser with rising edge detect.
// Assumes trig_in is a slow level from a periodic counter.
`timescale 1ns/1ps
module adcc_trig_sync (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Trigger
  input  wire logic trig_in,
  output logic      trig_rise
);
  logic [2:0] sync_q, sync_d;

  always_comb begin
    sync_d = {sync_q[1:0], trig_in};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_q <= 3'h0;
    end else begin
      sync_q <= sync_d;
    end
  end

  // Only the second and third stages feed the edge detect
  assign trig_rise = sync_q[1] && !sync_q[2]; // [R18]

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_one_pulse;
    trig_rise |=> !trig_rise;
  endproperty
  a_one_pulse: assert property (p_one_pulse) // [R18]
    else $error("trigger edge lasted more than one cycle");
endmodule

// ==== tb/adcc_ctrl_tb_top.sv ====
// Self-checking bench for the converter control block.
// Assumes adcc_pkg and adcc_regs.svh compiled first; bench plays the
// APB master, the analog converter and the trigger counter.
`timescale 1ns/1ps
module adcc_ctrl_tb_top;
  import adcc_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        hw_trigger_in;
  logic        result_low_rd;
  adcc_rsp_t   conv_rsp;
  adcc_req_t   conv_req;
  logic        result_load;
  logic        done_irq;
  logic [31:0] rd;
  logic        err;
  int          fail_count;
  int          comparisons;
  int          n_start;
  int          n_abort;
  int          n_load;
  int          s;
  int          a;
  int          l;
  logic        ge;
  logic        bl;
  logic        hit;
  // Ordinary cases: channel code and the source it must decode to
  logic [4:0]  row_ch  [6] = '{5'h00, 5'h0f, 5'h1b, 5'h1c, 5'h1d, 5'h1e};
  adcc_src_t   row_src [6] = '{ADCC_SRC_EXT, ADCC_SRC_EXT, ADCC_SRC_EXT,
                               ADCC_SRC_RSVD, ADCC_SRC_VREFH, ADCC_SRC_VREFL};

  adcc_ctrl uut (
    .pclk          (pclk),
    .presetn       (presetn),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .hw_trigger_in (hw_trigger_in),
    .conv_rsp      (conv_rsp),
    .result_low_rd (result_low_rd),
    .conv_req      (conv_req),
    .result_load   (result_load),
    .done_irq      (done_irq)
  );

  always #5 pclk = ~pclk;

  // Pulses counted mid-cycle so the count never races the clock edge
  always @(negedge pclk) begin
    n_start += (conv_req.start === 1'b1);
    n_abort += (conv_req.abort === 1'b1);
    n_load  += (result_load === 1'b1);
  end

  task automatic chk(input string nm, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; ends one edge after release so calls may chain
  task automatic apb(input logic w, input logic [7:0] ad, input logic [7:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("wait", n, 2);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] ad,
                       input logic [31:0] e);
    apb(1'b0, ad, 8'h00);
    chk(nm, rd, e);
  endtask

  // Converter finishes a running conversion
  task automatic fin(input logic b);
    repeat (2) @(posedge pclk);
    conv_rsp <= '{done: 1'b1, below: b};
    @(posedge pclk);
    conv_rsp <= '{done: 1'b0, below: 1'b0};
    repeat (3) @(posedge pclk);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hw_trigger_in = 1'b0;
    result_low_rd = 1'b0;
    conv_rsp = '{done: 1'b0, below: 1'b0};
    repeat (4) @(posedge pclk);
    chk("rst_pwrdn", conv_req.pwrdn, 1);
    chk("rst_src", conv_req.src, ADCC_SRC_OFF);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk("sc1_rst", 8'h00, 32'h1f);
    rdchk("sc2_rst", 8'h04, 32'h00);
    chk("mapped_err", err, 0);
    rdchk("unmapped", 8'h08, 32'h0);
    chk("unmapped_err", err, 1);
    for (int i = 0; i < 6; i++) begin
      s = n_start;
      l = n_load;
      apb(1'b1, 8'h00, {3'b000, row_ch[i]});
      rdchk("active", 8'h04, 32'h80);
      chk("chan", conv_req.chan, row_ch[i]);
      chk("src", conv_req.src, row_src[i]);
      chk("pwrdn_run", conv_req.pwrdn, 0);
      fin(1'b0);
      chk("starts", n_start - s, 1);
      chk("loads", n_load - l, 1);
      chk("pwrdn_idle", conv_req.pwrdn, 1);
      rdchk("flag", 8'h00, {24'h0, 3'b100, row_ch[i]});
      rdchk("idle", 8'h04, 32'h00);
    end
    // Interrupt raised, cleared by result read, masked, cleared by write
    apb(1'b1, 8'h00, 8'h43);
    fin(1'b0);
    chk("irq_on", done_irq, 1);
    result_low_rd <= 1'b1;
    @(posedge pclk);
    result_low_rd <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("irq_rd_clr", done_irq, 0);
    rdchk("flag_rd_clr", 8'h00, 32'h43);
    apb(1'b1, 8'h00, 8'h03);
    fin(1'b0);
    chk("irq_masked", done_irq, 0);
    rdchk("flag_masked", 8'h00, 32'h83);
    s = n_start;
    apb(1'b1, 8'h00, 8'h5f);
    repeat (3) @(posedge pclk);
    rdchk("flag_wr_clr", 8'h00, 32'h5f);
    chk("irq_wr_clr", done_irq, 0);
    chk("off_nostart", n_start - s, 0);
    // Every compare sense against both comparator outcomes
    for (int k = 0; k < 4; k++) begin
      ge = k[1];
      bl = k[0];
      hit = ge ? !bl : bl;
      apb(1'b1, 8'h04, {2'b00, 1'b1, ge, 4'h0});
      rdchk("sc2_cmp", 8'h04, {24'h0, 2'b00, 1'b1, ge, 4'h0});
      l = n_load;
      apb(1'b1, 8'h00, 8'h02);
      fin(bl);
      rdchk("cmp_flag", 8'h00, {24'h0, hit, 7'h02});
      chk("cmp_load", n_load - l, {31'h0, hit});
    end
    apb(1'b1, 8'h04, 8'h00);
    // Continuous run, then stopped by the off code
    s = n_start;
    apb(1'b1, 8'h00, 8'h26);
    fin(1'b0);
    fin(1'b0);
    chk("cont_starts", n_start - s, 3);
    s = n_start;
    a = n_abort;
    apb(1'b1, 8'h00, 8'h1f);
    repeat (6) @(posedge pclk);
    chk("stop_abort", n_abort - a, 1);
    chk("stop_nostart", n_start - s, 0);
    chk("stop_pwrdn", conv_req.pwrdn, 1);
    rdchk("stop_idle", 8'h04, 32'h00);
    // Rewrite in mid-conversion aborts and restarts
    s = n_start;
    a = n_abort;
    apb(1'b1, 8'h00, 8'h01);
    apb(1'b1, 8'h00, 8'h02);
    rdchk("restart_act", 8'h04, 32'h80);
    chk("restart_starts", n_start - s, 2);
    chk("restart_abort", n_abort - a, 1);
    chk("restart_chan", conv_req.chan, 5'h02);
    fin(1'b0);
    // Hardware trigger: armed by write, one start per rising edge
    apb(1'b1, 8'h04, 8'h40);
    s = n_start;
    apb(1'b1, 8'h00, 8'h04);
    repeat (4) @(posedge pclk);
    chk("hw_armed", n_start - s, 0);
    hw_trigger_in <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("hw_first", n_start - s, 1);
    fin(1'b0);
    repeat (8) @(posedge pclk);
    chk("hw_level", n_start - s, 1);
    hw_trigger_in <= 1'b0;
    repeat (4) @(posedge pclk);
    hw_trigger_in <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("hw_second", n_start - s, 2);
    fin(1'b0);
    hw_trigger_in <= 1'b0;
    rdchk("hw_flag", 8'h00, 32'h84);
    // Continuous run started by one trigger edge, then reset mid-run
    s = n_start;
    apb(1'b1, 8'h00, 8'h25);
    hw_trigger_in <= 1'b1;
    repeat (8) @(posedge pclk);
    fin(1'b0);
    chk("hw_cont", n_start - s, 2);
    hw_trigger_in <= 1'b0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("rst2_pwrdn", conv_req.pwrdn, 1);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk("rst2_sc1", 8'h00, 32'h1f);
    rdchk("rst2_sc2", 8'h04, 32'h00);
    tally_and_finish();
  end
endmodule
